// File: rtl/axil_reg_slave.sv
`timescale 1ns/1ps
module axil_reg_slave (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels
  input wire logic [pulse_pattern_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [pulse_pattern_pkg::AXI_DW-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels
  input wire logic arvalid,
  output logic arready,
  output logic [pulse_pattern_pkg::AXI_DW-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  output logic wr_en,
  output logic [pulse_pattern_pkg::AXI_AW-1:0] wr_addr,
  output logic [pulse_pattern_pkg::AXI_DW-1:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  input wire logic [pulse_pattern_pkg::AXI_DW-1:0] rd_data,
  input wire logic rd_err
);
  import pulse_pattern_pkg::*;

  logic aw_held_r;
  logic w_held_r;

  assign awready = !aw_held_r;
  assign wready = !w_held_r;
  assign arready = !rvalid;
  assign wr_en = aw_held_r && w_held_r && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      wr_addr <= '0;
    end else if (awvalid && awready) begin
      aw_held_r <= 1'b1;
      wr_addr <= awaddr;
    end else if (wr_en) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (wvalid && wready) begin
      w_held_r <= 1'b1;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end else if (wr_en) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// File: rtl/next_pair_stage.sv
`timescale 1ns/1ps
module next_pair_stage (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Trigger selection of upper and lower group
  input wire logic [pulse_pattern_pkg::SEL_W-1:0] sel_hi,
  input wire logic [pulse_pattern_pkg::SEL_W-1:0] sel_lo,
  input wire logic [pulse_pattern_pkg::NUM_CH-1:0] cmp_match,
  // Software access
  input wire logic wr_pair,
  input wire logic wr_alias,
  input wire logic [pulse_pattern_pkg::REG_W-1:0] wdata,
  output logic [pulse_pattern_pkg::REG_W-1:0] rd_pair,
  output logic [pulse_pattern_pkg::REG_W-1:0] rd_alias,
  // Staged data and group triggers
  output logic [pulse_pattern_pkg::REG_W-1:0] next_r,
  output logic trig_hi,
  output logic trig_lo,
  output logic same_trig
);
  import pulse_pattern_pkg::*;

  assign same_trig = (sel_hi == sel_lo);
  assign trig_hi = cmp_match[sel_hi];
  assign trig_lo = cmp_match[sel_lo];

  // whole byte in shared layout; split nibbles
  assign rd_pair = same_trig ? next_r : {next_r[7:4], RSVD_NIB};
  // alias reads all ones when shared
  assign rd_alias = same_trig ? RSVD_BYTE : {RSVD_NIB, next_r[3:0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      next_r <= RST_NEXT;
    end else if (wr_pair) begin
      next_r[7:4] <= wdata[7:4];
      if (same_trig) begin
        next_r[3:0] <= wdata[3:0];
      end
    end else if (wr_alias && !same_trig) begin
      next_r[3:0] <= wdata[3:0];
    end
  end

endmodule

// File: rtl/pulse_pattern_next_data_stage.sv
`timescale 1ns/1ps
// Functional notes
// - Low pair trigger copies low nibbles
// - High pair trigger copies high nibbles
// - Low next byte resets zero, kept
// - High next byte resets zero, kept
// - Layout chosen by comparing group triggers
// - Shared low trigger: one byte address
// - Shared low: alias reads ones, ignores writes
// - Split low: nibbles at two addresses
// - Shared high trigger: one byte address
// - Shared high: alias reserved, reads ones
// - Split high: nibbles at two addresses
// - Per-pin enable gates triggered copy
// - Low enable resets zero, kept
// - Trigger select two bits, resets ones
// - Enabled latch bits are software read-only
module pulse_pattern_next_data_stage (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [pulse_pattern_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data and response
  input wire logic [pulse_pattern_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [pulse_pattern_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [pulse_pattern_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Timer compare-match strobes, one per channel
  input wire logic [pulse_pattern_pkg::NUM_CH-1:0] cmp_match,
  // Per-pin enables of the upper groups, held elsewhere
  input wire logic [pulse_pattern_pkg::REG_W-1:0] high_pin_enables,
  // Pattern pins from the output data latch
  output logic [pulse_pattern_pkg::REG_W-1:0] pattern_pins_low,
  output logic [pulse_pattern_pkg::REG_W-1:0] pattern_pins_high
);
  import pulse_pattern_pkg::*;

  logic wr_en;
  logic [AXI_AW-1:0] wr_addr;
  logic [AXI_DW-1:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [AXI_DW-1:0] rd_data;
  logic rd_err;

  logic [REG_W-1:0] trig_sel_r;
  logic [REG_W-1:0] en_low_r;
  logic [LATCH_W-1:0] latch_r;
  logic [REG_W-1:0] next_low;
  logic [REG_W-1:0] next_high;
  logic [REG_W-1:0] rd_low_pair;
  logic [REG_W-1:0] rd_low_alias;
  logic [REG_W-1:0] rd_high_pair;
  logic [REG_W-1:0] rd_high_alias;
  logic same_low;
  logic same_high;
  logic [NUM_CH-1:0] trig_grp;
  logic [LATCH_W-1:0] en_all;
  logic [LATCH_W-1:0] next_all;
  logic [1:0] latch_byte_we;
  logic byte_we;

  axil_reg_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // Eight-bit registers sit in byte lane 0
  assign byte_we = wr_en && wr_strb[0];

  next_pair_stage u_low (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel_hi(trig_sel_r[SEL_G1 +: SEL_W]),
    .sel_lo(trig_sel_r[SEL_G0 +: SEL_W]),
    .cmp_match(cmp_match),
    .wr_pair(byte_we && wr_addr == ADDR_LOW_PAIR),
    .wr_alias(byte_we && wr_addr == ADDR_LOW_ALIAS),
    .wdata(wr_data[REG_W-1:0]),
    .rd_pair(rd_low_pair),
    .rd_alias(rd_low_alias),
    .next_r(next_low),
    .trig_hi(trig_grp[1]),
    .trig_lo(trig_grp[0]),
    .same_trig(same_low)
  );

  next_pair_stage u_high (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel_hi(trig_sel_r[SEL_G3 +: SEL_W]),
    .sel_lo(trig_sel_r[SEL_G2 +: SEL_W]),
    .cmp_match(cmp_match),
    .wr_pair(byte_we && wr_addr == ADDR_HIGH_PAIR),
    .wr_alias(byte_we && wr_addr == ADDR_HIGH_ALIAS),
    .wdata(wr_data[REG_W-1:0]),
    .rd_pair(rd_high_pair),
    .rd_alias(rd_high_alias),
    .next_r(next_high),
    .trig_hi(trig_grp[3]),
    .trig_lo(trig_grp[2]),
    .same_trig(same_high)
  );

  // Unmapped addresses answer with an error
  always_comb begin
    unique case (wr_addr)
      ADDR_LATCH, ADDR_TRIG_SEL, ADDR_EN_LOW, ADDR_HIGH_PAIR,
      ADDR_LOW_PAIR, ADDR_HIGH_ALIAS, ADDR_LOW_ALIAS: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    unique case (s_axi_araddr)
      ADDR_LATCH: rd_data[LATCH_W-1:0] = latch_r;
      ADDR_TRIG_SEL: rd_data[REG_W-1:0] = trig_sel_r;
      ADDR_EN_LOW: rd_data[REG_W-1:0] = en_low_r;
      ADDR_HIGH_PAIR: rd_data[REG_W-1:0] = rd_high_pair;
      ADDR_LOW_PAIR: rd_data[REG_W-1:0] = rd_low_pair;
      ADDR_HIGH_ALIAS: rd_data[REG_W-1:0] = rd_high_alias;
      ADDR_LOW_ALIAS: rd_data[REG_W-1:0] = rd_low_alias;
      default: rd_err = 1'b1;
    endcase
  end

  // trigger select resets to channel 3
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_sel_r <= RST_TRIG_SEL;
    end else if (byte_we && wr_addr == ADDR_TRIG_SEL) begin
      trig_sel_r <= wr_data[REG_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_low_r <= RST_EN_LOW;
    end else if (byte_we && wr_addr == ADDR_EN_LOW) begin
      en_low_r <= wr_data[REG_W-1:0];
    end
  end

  assign en_all = {high_pin_enables, en_low_r};
  assign next_all = {next_high, next_low};
  assign latch_byte_we[0] = wr_en && wr_addr == ADDR_LATCH && wr_strb[0];
  assign latch_byte_we[1] = wr_en && wr_addr == ADDR_LATCH && wr_strb[1];

  // One flip-flop per pin of the output data latch
  for (genvar i = 0; i < LATCH_W; i++) begin : g_latch
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        latch_r[i] <= RST_LATCH[i];
      end else if (trig_grp[i/NIB_W] && en_all[i]) begin
        latch_r[i] <= next_all[i];
      end else if (latch_byte_we[i/REG_W] && !en_all[i]) begin
        latch_r[i] <= wr_data[i];
      end
    end
  end

  assign pattern_pins_low = latch_r[REG_W-1:0];
  assign pattern_pins_high = latch_r[LATCH_W-1:REG_W];

  low_copy_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (trig_grp[0] || trig_grp[1]) |=>
      (((latch_r[7:0] ^ $past(next_low)) & $past(en_low_r)
        & {{4{$past(trig_grp[1])}}, {4{$past(trig_grp[0])}}}) == 8'h00))
    else $error("low group copy missed");

  high_copy_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (trig_grp[2] || trig_grp[3]) |=>
      (((latch_r[15:8] ^ $past(next_high)) & $past(high_pin_enables)
        & {{4{$past(trig_grp[3])}}, {4{$past(trig_grp[2])}}}) == 8'h00))
    else $error("high group copy missed");

  // disabled pins hold without a software write
  blocked_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (latch_byte_we == 2'b00) |=>
      (((latch_r ^ $past(latch_r)) & ~$past(en_all)) == 16'h0000))
    else $error("disabled pin changed");

  read_only_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (latch_byte_we != 2'b00 && trig_grp == 4'h0) |=>
      (((latch_r ^ $past(latch_r)) & $past(en_all)) == 16'h0000))
    else $error("enabled pin written by software");

  reset_vals_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (trig_sel_r == 8'hFF && en_low_r == 8'h00
      && next_low == 8'h00 && next_high == 8'h00))
    else $error("reset value wrong");

  low_alias_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && same_low
      && s_axi_araddr == ADDR_LOW_ALIAS) |=>
      (s_axi_rvalid && s_axi_rdata == 32'h000000FF))
    else $error("shared low alias not all ones");

  alias_wr_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_en && same_low && wr_addr == ADDR_LOW_ALIAS) |=>
      (next_low == $past(next_low)))
    else $error("shared low alias was written");

  high_alias_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && same_high
      && s_axi_araddr == ADDR_HIGH_ALIAS) |=>
      (s_axi_rdata[7:0] == 8'hFF))
    else $error("shared high alias not all ones");

  // split low pair reads ones in low nibble
  split_low_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && !same_low
      && s_axi_araddr == ADDR_LOW_PAIR) |=>
      (s_axi_rdata[3:0] == 4'hF
        && s_axi_rdata[7:4] == $past(next_low[7:4])))
    else $error("split low pair layout wrong");

  // split high alias carries group 2 nibble
  split_high_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_en && wr_strb[0] && !same_high
      && wr_addr == ADDR_HIGH_ALIAS) |=>
      (next_high[3:0] == $past(wr_data[3:0])
        && next_high[7:4] == $past(next_high[7:4])))
    else $error("split high alias write wrong");

  // shared high pair takes the whole byte
  shared_high_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_en && wr_strb[0] && same_high
      && wr_addr == ADDR_HIGH_PAIR) |=>
      (next_high == $past(wr_data[7:0])))
    else $error("shared high pair write wrong");

  // shared low pair takes the whole byte
  shared_low_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_en && wr_strb[0] && same_low
      && wr_addr == ADDR_LOW_PAIR) |=>
      (next_low == $past(wr_data[7:0])))
    else $error("shared low pair write wrong");

  // split low pair keeps group 0 nibble
  split_low_wr_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_en && wr_strb[0] && !same_low
      && wr_addr == ADDR_LOW_PAIR) |=>
      (next_low[7:4] == $past(wr_data[7:4])
        && next_low[3:0] == $past(next_low[3:0])))
    else $error("split low pair write wrong");

  // equal selects give the whole byte
  layout_pick_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_LOW_PAIR
      && trig_sel_r[SEL_G1 +: SEL_W] == trig_sel_r[SEL_G0 +: SEL_W]) |=>
      (s_axi_rdata == {24'h000000, $past(next_low)}))
    else $error("low pair layout not chosen by selects");

  high_alias_wr_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_en && same_high && wr_addr == ADDR_HIGH_ALIAS) |=>
      (next_high == $past(next_high)))
    else $error("shared high alias was written");

  enable_wr_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_en && wr_strb[0] && wr_addr == ADDR_EN_LOW) |=>
      (en_low_r == $past(wr_data[7:0])))
    else $error("low enable write lost");

  trig_sel_wr_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (wr_en && wr_strb[0] && wr_addr == ADDR_TRIG_SEL) |=>
      (trig_sel_r == $past(wr_data[7:0])))
    else $error("trigger select write lost");

  triggered_copy_c: cover property (@(posedge aclk) disable iff (!aresetn)
    trig_grp[0] && en_low_r[0] && next_low[0] != latch_r[0]);
  split_layout_c: cover property (@(posedge aclk) disable iff (!aresetn)
    !same_low && wr_en && wr_addr == ADDR_LOW_ALIAS);
  blocked_write_c: cover property (@(posedge aclk) disable iff (!aresetn)
    latch_byte_we[0] && en_low_r != 8'h00);
  back_to_back_c: cover property (@(posedge aclk) disable iff (!aresetn)
    trig_grp[2] ##1 trig_grp[2]);

endmodule

// File: rtl/pulse_pattern_pkg.sv
package pulse_pattern_pkg;

  // Bus and register widths
  localparam int AXI_AW = 32;
  localparam int AXI_DW = 32;
  localparam int REG_W = 8;
  localparam int LATCH_W = 16;
  localparam int SEL_W = 2;
  localparam int NUM_CH = 4;
  localparam int NIB_W = 4;

  // Register indices; the byte address is four times the index
  localparam logic [27:0] IDX_LATCH = 28'h5FFFFC2;
  localparam logic [27:0] IDX_TRIG_SEL = 28'h5FFFFF1;
  localparam logic [27:0] IDX_EN_LOW = 28'h5FFFFF3;
  localparam logic [27:0] IDX_HIGH_PAIR = 28'h5FFFFF4;
  localparam logic [27:0] IDX_LOW_PAIR = 28'h5FFFFF5;
  localparam logic [27:0] IDX_HIGH_ALIAS = 28'h5FFFFF6;
  localparam logic [27:0] IDX_LOW_ALIAS = 28'h5FFFFF7;

  localparam logic [31:0] ADDR_LATCH = {2'b00, IDX_LATCH, 2'b00};
  localparam logic [31:0] ADDR_TRIG_SEL = {2'b00, IDX_TRIG_SEL, 2'b00};
  localparam logic [31:0] ADDR_EN_LOW = {2'b00, IDX_EN_LOW, 2'b00};
  localparam logic [31:0] ADDR_HIGH_PAIR = {2'b00, IDX_HIGH_PAIR, 2'b00};
  localparam logic [31:0] ADDR_LOW_PAIR = {2'b00, IDX_LOW_PAIR, 2'b00};
  localparam logic [31:0] ADDR_HIGH_ALIAS = {2'b00, IDX_HIGH_ALIAS, 2'b00};
  localparam logic [31:0] ADDR_LOW_ALIAS = {2'b00, IDX_LOW_ALIAS, 2'b00};

  // Reset values
  localparam logic [7:0] RST_NEXT = 8'h00;
  localparam logic [7:0] RST_EN_LOW = 8'h00;
  localparam logic [7:0] RST_TRIG_SEL = 8'hFF;
  localparam logic [15:0] RST_LATCH = 16'h0000;

  // Read value of reserved bits
  localparam logic [3:0] RSVD_NIB = 4'hF;
  localparam logic [7:0] RSVD_BYTE = 8'hFF;

  // Trigger-select field positions (low bit of each two-bit field)
  localparam int SEL_G0 = 0;
  localparam int SEL_G1 = 2;
  localparam int SEL_G2 = 4;
  localparam int SEL_G3 = 6;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// File: test/tb_pulse_pattern_next_data_stage.sv
`timescale 1ns/1ps
module tb_pulse_pattern_next_data_stage;
  import pulse_pattern_pkg::*;
  logic aclk, aresetn;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb, cmp_match, go, dly;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [7:0] hi_en, pins_lo, pins_hi;
  int failures, n_compared, cycles;

  pulse_pattern_next_data_stage i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cmp_match(cmp_match),
    .high_pin_enables(hi_en), .pattern_pins_low(pins_lo),
    .pattern_pins_high(pins_hi)
  );

  timer_strobe_model i_tmr (
    .aclk(aclk), .aresetn(aresetn), .go(go), .dly(dly),
    .cmp_match(cmp_match)
  );

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic fire(input logic [3:0] m, input logic [3:0] d);
    go <= m;
    dly <= d;
    @(posedge aclk);
    go <= 4'h0;
    repeat (d + 3) @(posedge aclk);
  endtask

  task automatic pins(input logic [15:0] e);
    chk({16'h0, pins_hi, pins_lo}, {16'h0, e});
  endtask

  task automatic reset_check();
    rd(ADDR_LOW_PAIR, 32'h00, RESP_OKAY);
    rd(ADDR_HIGH_PAIR, 32'h00, RESP_OKAY);
    rd(ADDR_LOW_ALIAS, 32'hFF, RESP_OKAY);
    rd(ADDR_HIGH_ALIAS, 32'hFF, RESP_OKAY);
    rd(ADDR_EN_LOW, 32'h00, RESP_OKAY);
    rd(ADDR_TRIG_SEL, 32'hFF, RESP_OKAY);
    pins(16'h0000);
  endtask

  // Split layout triggers: channel, expected pins after each copy
  logic [3:0] ch_tab [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  logic [15:0] pin_tab [4] = '{16'h3FF9, 16'h3F69, 16'h3269, 16'h7269};

  initial begin
    aresetn = 1'b0;
    {awaddr, wdata, araddr, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    go = 4'h0;
    dly = 4'h0;
    hi_en = 8'hF0;
    failures = 0;
    n_compared = 0;
    cycles = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    reset_check();
    rd(32'h10, 32'h0, RESP_SLVERR);
    wr(32'h10, 32'h5A, RESP_SLVERR);
    // Shared layout for both pairs
    wr(ADDR_LOW_PAIR, 32'hA5, RESP_OKAY);
    wr(ADDR_HIGH_PAIR, 32'h3C, RESP_OKAY);
    wr(ADDR_LOW_ALIAS, 32'hFF, RESP_OKAY);
    wr(ADDR_HIGH_ALIAS, 32'hFF, RESP_OKAY);
    rd(ADDR_LOW_ALIAS, 32'hFF, RESP_OKAY);
    rd(ADDR_LOW_PAIR, 32'hA5, RESP_OKAY);
    rd(ADDR_HIGH_PAIR, 32'h3C, RESP_OKAY);
    // Partial enables gate the copy
    wr(ADDR_EN_LOW, 32'h0F, RESP_OKAY);
    rd(ADDR_EN_LOW, 32'h0F, RESP_OKAY);
    fire(4'h8, 4'h0);
    pins(16'h3005);
    // Enabled latch bits refuse software writes
    wr(ADDR_LATCH, 32'hFFFF, RESP_OKAY);
    rd(ADDR_LATCH, 32'h3FF5, RESP_OKAY);
    pins(16'h3FF5);
    // Split layout: each group on its own channel
    wr(ADDR_TRIG_SEL, 32'hE4, RESP_OKAY);
    rd(ADDR_TRIG_SEL, 32'hE4, RESP_OKAY);
    rd(ADDR_LOW_PAIR, 32'hAF, RESP_OKAY);
    rd(ADDR_LOW_ALIAS, 32'hF5, RESP_OKAY);
    rd(ADDR_HIGH_PAIR, 32'h3F, RESP_OKAY);
    rd(ADDR_HIGH_ALIAS, 32'hFC, RESP_OKAY);
    wr(ADDR_LOW_PAIR, 32'h6F, RESP_OKAY);
    wr(ADDR_LOW_ALIAS, 32'hF9, RESP_OKAY);
    wr(ADDR_HIGH_PAIR, 32'h7F, RESP_OKAY);
    wr(ADDR_HIGH_ALIAS, 32'hF2, RESP_OKAY);
    rd(ADDR_LOW_PAIR, 32'h6F, RESP_OKAY);
    rd(ADDR_LOW_ALIAS, 32'hF9, RESP_OKAY);
    rd(ADDR_HIGH_PAIR, 32'h7F, RESP_OKAY);
    rd(ADDR_HIGH_ALIAS, 32'hF2, RESP_OKAY);
    wr(ADDR_EN_LOW, 32'hFF, RESP_OKAY);
    hi_en <= 8'hFF;
    for (int i = 0; i < 4; i++) begin
      fire(ch_tab[i], 4'(i));
      pins(pin_tab[i]);
    end
    // Back to shared: stored bits kept
    wr(ADDR_TRIG_SEL, 32'hFF, RESP_OKAY);
    rd(ADDR_LOW_PAIR, 32'h69, RESP_OKAY);
    rd(ADDR_HIGH_PAIR, 32'h72, RESP_OKAY);
    // Disabled bits stay put under a slow strobe
    wr(ADDR_EN_LOW, 32'h00, RESP_OKAY);
    wr(ADDR_LOW_PAIR, 32'h00, RESP_OKAY);
    hi_en <= 8'h00;
    wr(ADDR_HIGH_PAIR, 32'h00, RESP_OKAY);
    fire(4'h8, 4'h9);
    pins(16'h7269);
    // Second reset in mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    reset_check();
    summarize();
  end
endmodule

// File: test/timer_strobe_model.sv
`timescale 1ns/1ps
module timer_strobe_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request: channel mask and delay in cycles
  input wire logic [pulse_pattern_pkg::NUM_CH-1:0] go,
  input wire logic [3:0] dly,
  // Compare-match strobes
  output logic [pulse_pattern_pkg::NUM_CH-1:0] cmp_match
);
  import pulse_pattern_pkg::*;
  logic [NUM_CH-1:0] pend_r;
  logic [3:0] cnt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_r <= '0;
      cnt_r <= 4'h0;
      cmp_match <= '0;
    end else begin
      cmp_match <= '0;
      if (go != '0) begin
        pend_r <= go;
        cnt_r <= dly;
      end else if (pend_r != '0) begin
        if (cnt_r == 4'h0) begin
          cmp_match <= pend_r;
          pend_r <= '0;
        end else begin
          cnt_r <= cnt_r - 4'h1;
        end
      end
    end
  end
endmodule
